// ### design/awu_regs.vh
// register offsets, field positions, reset values and periods of the wakeup unit
`ifndef AWU_REGS_VH
`define AWU_REGS_VH

// ==========================================================
// register byte offsets
`define ADDR_PORT_A_DATA 6'h00
`define ADDR_KBD_STATUS_CTRL 6'h04
`define ADDR_KBD_IRQ_ENABLE 6'h08
`define ADDR_CONFIG_TWO 6'h0C
`define ADDR_CONFIG_ONE 6'h10
`define ADDR_WAKE_COUNT 6'h14

// ==========================================================
// field positions
`define BIT_WAKEUP_LATCH 6
`define BIT_KEYBOARD_FLAG 3
`define BIT_KEYBOARD_ACK 2
`define BIT_KEYBOARD_IRQ_MASK 1
`define BIT_WAKEUP_IRQ_ENABLE 6
`define BIT_OSC_RUN_IN_STOP 1
`define BIT_PERIOD_SELECT 0

// ==========================================================
// reset values
`define RST_KEYBOARD_IRQ_MASK 1'b0
`define RST_WAKEUP_IRQ_ENABLE 1'b0
`define RST_OSC_RUN_IN_STOP 1'b0
`define RST_PERIOD_SELECT 1'b0

// ==========================================================
// wakeup periods in counter clock cycles
`define AWU_SHORT_PERIOD 512
`define AWU_LONG_PERIOD 16384

`endif

// ### design/sticky_flag.v
// sticky flag whose set wins over a simultaneous clear
`timescale 1ns/100ps
module sticky_flag (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // control
  input wire set,
  input wire clr,
  // state
  output reg flag_ff
);

  wire nxt_flag;

  // a set arriving with the clear is kept so no request is lost
  assign nxt_flag = set | (flag_ff & ~clr);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

endmodule

// ### design/wake_counter.v
// wakeup period counter, running only while stopped
`timescale 1ns/100ps
module wake_counter #(
  parameter CW = 14
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // control
  input wire run,
  input wire restart,
  input wire tick,
  input wire [CW-1:0] last_count,
  // results
  output reg [CW-1:0] count_ff,
  output reg overflow_ff
);

  reg [CW-1:0] nxt_count;
  reg nxt_overflow;

  always @* begin
    nxt_count = count_ff;
    nxt_overflow = 1'b0;
    if (restart || !run) begin
      nxt_count = {CW{1'b0}};
    end else if (tick) begin
      if (count_ff == last_count) begin
        nxt_count = {CW{1'b0}};
        nxt_overflow = 1'b1;
      end else begin
        nxt_count = count_ff + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= {CW{1'b0}};
      overflow_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      overflow_ff <= nxt_overflow;
    end
  end

endmodule

// ### design/auto_wake_unit.v
// auto wakeup unit with keyboard interrupt sharing and avalon register slave
//
// Notes on behaviour
// - periodic wakeup requests are produced while the device is stopped.
// - wakeup requests share keyboard flag, acknowledge, mask and vector.
// - counter idles in run mode and counts in stop while enable is set and wait mode is clear.
// - nothing counts and no request appears during wait mode.
// - counter returns to zero each time stop is entered.
// - request input high with wakeup enable set sets the wakeup latch.
// - counter ticks from rc oscillator, or doubled bus clock if selected.
// - reaching the overflow count latches a request and passes it on.
// - period select one chooses short period, zero the long one.
// - short period is 512 ticks, long period 16384 ticks.
// - wakeup latch reads at bit 6 of port a data, read only.
// - keyboard acknowledge write or reset clears the wakeup latch.
// - writing one to acknowledge clears pending requests; it reads zero.
// - wakeup enable does not alter the latch value software reads.
// - latched wakeup interrupts only while wakeup enable is set.
// - with enable set, stop entry starts unit; exit needs mask clear.
// - mask set blocks keyboard and wakeup interrupts; reset clears mask.
`timescale 1ns/100ps
`include "awu_regs.vh"
module auto_wake_unit #(
  parameter SHORT_PERIOD = `AWU_SHORT_PERIOD,
  parameter LONG_PERIOD = `AWU_LONG_PERIOD,
  parameter CW = 14
) (
  // clock and reset
  input wire CORE_CLK,
  input wire RSTN,
  // avalon-mm register slave
  input wire [5:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  output reg [31:0] AVS_READDATA,
  output reg AVS_WAITREQUEST,
  // power mode status from the core
  input wire STOP_MODE,
  input wire WAIT_MODE,
  // counter clock ticks, one cycle each
  input wire WAKEUP_RC_OSC,
  input wire BUS_CLOCK_DOUBLE,
  // keyboard pin request, already edge or level detected
  input wire KEYBOARD_PIN_REQ,
  // outputs to interrupt and stop control
  output reg KBD_IRQ,
  output reg STOP_EXIT,
  output reg WAKEUP_REQUEST
);

  // ==========================================================
  // control state
  reg keyboard_irq_mask_ff;
  reg wakeup_irq_enable_ff;
  reg osc_run_in_stop_ff;
  reg period_select_ff;
  reg stop_prev_ff;
  reg pin_pending_ff;

  wire wakeup_latch;
  wire keyboard_flag;
  wire [CW-1:0] count;
  wire overflow;

  // ==========================================================
  // bus decode
  wire bus_req;
  wire bus_go;
  wire wr_go;
  wire keyboard_ack;

  assign bus_req = AVS_READ | AVS_WRITE;
  // the cycle in which waitrequest is low is the one that completes
  assign bus_go = bus_req & ~AVS_WAITREQUEST;
  assign wr_go = bus_go & AVS_WRITE;
  assign keyboard_ack = wr_go & (AVS_ADDRESS == `ADDR_KBD_STATUS_CTRL) &
    AVS_WRITEDATA[`BIT_KEYBOARD_ACK];

  // ==========================================================
  // counter
  wire stop_entry;
  wire run;
  wire tick;
  wire [CW-1:0] last_count;

  assign stop_entry = STOP_MODE & ~stop_prev_ff;
  // wait mode never counts, even if both strobes arrive together
  assign run = STOP_MODE & ~WAIT_MODE & wakeup_irq_enable_ff;
  assign tick = osc_run_in_stop_ff ? BUS_CLOCK_DOUBLE
    : WAKEUP_RC_OSC;
  assign last_count = period_select_ff
    ? SHORT_PERIOD[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}
    : LONG_PERIOD[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};

  wake_counter #(
    .CW(CW)
  ) u_counter (
    .clk(CORE_CLK),
    .rst_n(RSTN),
    .run(run),
    .restart(stop_entry),
    .tick(tick),
    .last_count(last_count),
    .count_ff(count),
    .overflow_ff(overflow)
  );

  // ==========================================================
  // request latches
  wire wake_set;

  // overflow pulse is the wakeup request input
  assign wake_set = overflow & wakeup_irq_enable_ff &
    STOP_MODE & ~WAIT_MODE;

  sticky_flag u_wake_latch (
    .clk(CORE_CLK),
    .rst_n(RSTN),
    .set(wake_set),
    .clr(keyboard_ack),
    .flag_ff(wakeup_latch)
  );

  // keyboard pin and wakeup share one flag and one acknowledge
  assign keyboard_flag = pin_pending_ff | wakeup_latch;

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_pending_ff <= 1'b0;
      stop_prev_ff <= 1'b0;
    end else begin
      pin_pending_ff <= KEYBOARD_PIN_REQ | (pin_pending_ff & ~keyboard_ack);
      stop_prev_ff <= STOP_MODE;
    end
  end

  // ==========================================================
  // control registers
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      keyboard_irq_mask_ff <= `RST_KEYBOARD_IRQ_MASK;
      wakeup_irq_enable_ff <= `RST_WAKEUP_IRQ_ENABLE;
      osc_run_in_stop_ff <= `RST_OSC_RUN_IN_STOP;
      period_select_ff <= `RST_PERIOD_SELECT;
    end else if (wr_go) begin
      case (AVS_ADDRESS)
        `ADDR_KBD_STATUS_CTRL: begin
          keyboard_irq_mask_ff <= AVS_WRITEDATA[`BIT_KEYBOARD_IRQ_MASK];
        end
        `ADDR_KBD_IRQ_ENABLE: begin
          wakeup_irq_enable_ff <= AVS_WRITEDATA[`BIT_WAKEUP_IRQ_ENABLE];
        end
        `ADDR_CONFIG_TWO: begin
          osc_run_in_stop_ff <= AVS_WRITEDATA[`BIT_OSC_RUN_IN_STOP];
        end
        `ADDR_CONFIG_ONE: begin
          period_select_ff <= AVS_WRITEDATA[`BIT_PERIOD_SELECT];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // read path and waitrequest
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (AVS_ADDRESS)
      `ADDR_PORT_A_DATA: begin
        // enable is deliberately not in this term
        rd_mux[`BIT_WAKEUP_LATCH] = wakeup_latch;
      end
      `ADDR_KBD_STATUS_CTRL: begin
        rd_mux[`BIT_KEYBOARD_FLAG] = keyboard_flag;
        rd_mux[`BIT_KEYBOARD_IRQ_MASK] = keyboard_irq_mask_ff;
      end
      `ADDR_KBD_IRQ_ENABLE: begin
        rd_mux[`BIT_WAKEUP_IRQ_ENABLE] = wakeup_irq_enable_ff;
      end
      `ADDR_CONFIG_TWO: begin
        rd_mux[`BIT_OSC_RUN_IN_STOP] = osc_run_in_stop_ff;
      end
      `ADDR_CONFIG_ONE: begin
        rd_mux[`BIT_PERIOD_SELECT] = period_select_ff;
      end
      `ADDR_WAKE_COUNT: begin
        rd_mux[CW-1:0] = count;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // fixed one wait state keeps read data registered
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0000_0000;
    end else begin
      AVS_WAITREQUEST <= ~(bus_req & AVS_WAITREQUEST);
      if (bus_req & AVS_WAITREQUEST & AVS_READ) begin
        AVS_READDATA <= rd_mux;
      end
    end
  end

  // ==========================================================
  // interrupt and stop exit outputs
  wire wake_pending;
  wire irq_now;

  assign wake_pending = wakeup_latch & wakeup_irq_enable_ff;
  assign irq_now = (pin_pending_ff | wake_pending) &
    ~keyboard_irq_mask_ff;

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      KBD_IRQ <= 1'b0;
      STOP_EXIT <= 1'b0;
      WAKEUP_REQUEST <= 1'b0;
    end else begin
      KBD_IRQ <= irq_now;
      STOP_EXIT <= irq_now & STOP_MODE;
      WAKEUP_REQUEST <= wake_set;
    end
  end

endmodule

// ### bench/awu_chk_sva.sv
// port checker for the auto wakeup unit
`timescale 1ns/100ps
module awu_chk (
  // clock and reset
  input wire CORE_CLK,
  input wire RSTN,
  // register bus
  input wire [5:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [31:0] AVS_READDATA,
  input wire AVS_WAITREQUEST,
  // modes and events
  input wire STOP_MODE,
  input wire WAIT_MODE,
  input wire KEYBOARD_PIN_REQ,
  input wire KBD_IRQ,
  input wire STOP_EXIT,
  input wire WAKEUP_REQUEST
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  // ====
  // the four-cycle margin covers the tick-to-request pipeline
  AST_RUN_IDLE: assert property (!STOP_MODE[*4] |=> !WAKEUP_REQUEST)
    else $error("wakeup request outside stop");
  AST_WAIT_IDLE: assert property (WAIT_MODE[*4] |=> !WAKEUP_REQUEST)
    else $error("wakeup request in wait");
  AST_REQ_GAP: assert property (WAKEUP_REQUEST |=> !WAKEUP_REQUEST[*3])
    else $error("wakeup requests too close");
  AST_EXIT_IRQ: assert property (STOP_EXIT |-> KBD_IRQ && $past(STOP_MODE))
    else $error("stop exit without irq in stop");
  AST_WAIT_ONE: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus answer late");
  AST_WAIT_SHORT: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  AST_ACK_READ0: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 6'h04 |-> !AVS_READDATA[2])
    else $error("acknowledge bit reads one");
  AST_ACK_CLEAR: assert property (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 6'h04 && AVS_WRITEDATA[2] && !STOP_MODE && !KEYBOARD_PIN_REQ |-> ##[1:2] !KBD_IRQ)
    else $error("acknowledge left irq pending");
  AST_RESET_OUT: assert property ($rose(RSTN) |-> !KBD_IRQ && !STOP_EXIT && !WAKEUP_REQUEST)
    else $error("outputs active after reset");
  cover property (WAKEUP_REQUEST && STOP_MODE);
  cover property (STOP_EXIT);
  cover property (WAKEUP_REQUEST && !KBD_IRQ);
endmodule

bind auto_wake_unit awu_chk i_awu_chk (.CORE_CLK, .RSTN, .AVS_ADDRESS,
  .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST,
  .STOP_MODE, .WAIT_MODE, .KEYBOARD_PIN_REQ, .KBD_IRQ, .STOP_EXIT,
  .WAKEUP_REQUEST);

// ### bench/cpu_wake_model.sv
// processor stop control: enters stop on command, leaves on wake request
`timescale 1ns/100ps
module cpu_wake_model (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // command and wake
  input wire stop_cmd,
  input wire exit_req,
  output reg stop_mode
);
  reg cmd_ff;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_mode <= 1'b0;
      cmd_ff <= 1'b0;
    end else begin
      cmd_ff <= stop_cmd;
      if (!stop_cmd || exit_req) begin
        stop_mode <= 1'b0;
      end else if (!cmd_ff) begin
        stop_mode <= 1'b1;
      end
    end
  end
endmodule

// ### bench/tb.sv
// self-checking bench for the auto wakeup unit
`timescale 1ns/100ps
module tb;
  logic CORE_CLK, RSTN, AVS_READ, AVS_WRITE, STOP_MODE, WAIT_MODE, s;
  logic WAKEUP_RC_OSC, BUS_CLOCK_DOUBLE, KEYBOARD_PIN_REQ, stop_cmd;
  logic KBD_IRQ, STOP_EXIT, WAKEUP_REQUEST, AVS_WAITREQUEST;
  logic [5:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, q;
  logic [7:0] lf;
  int fails, checks_done, per, c;
  bit osc;
  auto_wake_unit #(.SHORT_PERIOD(4), .LONG_PERIOD(16)) i_auto_wake_unit (
    .CORE_CLK, .RSTN, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
    .AVS_READDATA, .AVS_WAITREQUEST, .STOP_MODE, .WAIT_MODE, .WAKEUP_RC_OSC,
    .BUS_CLOCK_DOUBLE, .KEYBOARD_PIN_REQ, .KBD_IRQ, .STOP_EXIT,
    .WAKEUP_REQUEST);
  cpu_wake_model i_cpu_wake_model (.clk(CORE_CLK), .rst_n(RSTN),
    .stop_cmd(stop_cmd), .exit_req(STOP_EXIT), .stop_mode(STOP_MODE));
  // ====
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic int period(input bit ps);
    return ps ? 4 : 16;
  endfunction
  initial begin
    CORE_CLK = 1'b0;
    forever #10 CORE_CLK = ~CORE_CLK;
  end
  task wrap_up;
    begin
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      checks_done++;
      if (g !== e) begin
        fails++;
        $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task bus(input bit w, input logic [5:0] a, input logic [31:0] d,
           output logic [31:0] r);
    begin
      @(posedge CORE_CLK);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_WRITE <= w;
      AVS_READ <= !w;
      do @(posedge CORE_CLK); while (AVS_WAITREQUEST !== 1'b0);
      r = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
    end
  endtask
  // unselected source gets random ticks too, so a wrong pick shows early
  task tk(input int k);
    int i;
    begin
      i = 0;
      while (i < k) begin
        @(posedge CORE_CLK);
        lf = nxt(lf);
        WAKEUP_RC_OSC <= osc ? lf[1] : lf[0];
        BUS_CLOCK_DOUBLE <= osc ? lf[0] : lf[1];
        i += lf[0];
      end
      @(posedge CORE_CLK);
      WAKEUP_RC_OSC <= 1'b0;
      BUS_CLOCK_DOUBLE <= 1'b0;
    end
  endtask
  task wq(output logic f);
    begin
      f = 1'b0;
      repeat (6) begin
        @(posedge CORE_CLK);
        if (WAKEUP_REQUEST === 1'b1) f = 1'b1;
      end
    end
  endtask
  task stop(input bit on);
    begin
      stop_cmd <= on;
      repeat (3) @(posedge CORE_CLK);
    end
  endtask
  initial begin
    #200000;
    fails++;
    wrap_up;
  end
  // ====
  initial begin
    RSTN = 1'b0; AVS_READ = 1'b0; AVS_WRITE = 1'b0; AVS_ADDRESS = 6'h00;
    AVS_WRITEDATA = 32'h0000_0000; WAIT_MODE = 1'b0; stop_cmd = 1'b0;
    WAKEUP_RC_OSC = 1'b0; BUS_CLOCK_DOUBLE = 1'b0; KEYBOARD_PIN_REQ = 1'b0;
    lf = 8'h30; fails = 0; checks_done = 0; osc = 1'b0;
    repeat (5) @(posedge CORE_CLK);
    RSTN <= 1'b1;
    bus(0, 6'h04, 0, q); chk("kbd_status_reset", 0, q);
    bus(0, 6'h00, 0, q); chk("latch_reset", 0, q);
    bus(0, 6'h3C, 0, q); chk("unmapped", 0, q);
    bus(1, 6'h08, 32'h0000_0040, q);
    tk(20); wq(s); chk("run_idle", 0, s);
    WAIT_MODE <= 1'b1;
    stop(1);
    tk(20); wq(s); chk("wait_idle", 0, s);
    WAIT_MODE <= 1'b0;
    stop(0);
    KEYBOARD_PIN_REQ <= 1'b1;
    @(posedge CORE_CLK);
    KEYBOARD_PIN_REQ <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
    chk("pin_irq", 1, KBD_IRQ);
    bus(0, 6'h04, 0, q); chk("pin_flag", 32'h0000_0008, q);
    bus(1, 6'h04, 32'h0000_0004, q);
    bus(0, 6'h04, 0, q); chk("pin_ack", 0, q);
    for (c = 0; c < 4; c++) begin
      osc = c[1];
      per = period(c[0]);
      bus(1, 6'h0C, {30'd0, osc, 1'b0}, q);
      bus(1, 6'h10, {31'd0, c[0]}, q);
      bus(1, 6'h04, {30'd0, c == 3, 1'b0}, q);
      stop(1); tk(per - 1); stop(0); stop(1);
      tk(per - 1); wq(s); chk("early", 0, s);
      bus(0, 6'h14, 0, q); chk("count", per - 1, q);
      tk(1); wq(s); chk("overflow", 1, s);
      chk("irq", c != 3, KBD_IRQ);
      chk("stop_kept", c == 3, STOP_MODE);
      if (c == 3) begin
        tk(per); wq(s); chk("again", 1, s);
      end
      bus(1, 6'h08, 0, q);
      bus(0, 6'h00, 0, q); chk("latch", 32'h0000_0040, q);
      bus(1, 6'h04, 32'h0000_0004, q);
      bus(0, 6'h00, 0, q); chk("ack", 0, q);
      bus(1, 6'h08, 32'h0000_0040, q);
      stop(0);
    end
    wrap_up;
  end
endmodule
